// ### bench/acsr_bank_tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/100ps
`default_nettype none
module acsr_bank_tb;
	localparam logic [5:0] SW [6] = '{6'h00, 6'h1B, 6'h32, 6'h14, 6'h3E,
		6'h0F};
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic feat_en = 1'b0;
	logic sen_n;
	logic sclk;
	logic sdata;
	logic pin_o;
	logic oe_n;
	logic srst;
	wire logic serial_readout_pin_w;
	acsr_pkg::acsr_cfg_t cfg;
	int error_cnt = 0;
	int n_compared = 0;
	int srst_seen = 0;
	logic [7:0] exp_q [$];
	logic [7:0] shadow [acsr_pkg::NUM_REGS];
	logic [7:0] rd;
	logic rd_stb = 1'b0;

	always #5 clk_sys = ~clk_sys;
	// released pin floats so a stray sample reads unknown
	assign serial_readout_pin_w = oe_n ? 1'bz : pin_o;

	acsr_bank dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .sen_n(sen_n),
		.sclk(sclk), .sdata(sdata), .digital_features_en(feat_en),
		.serial_readout_pin_o(pin_o), .serial_readout_pin_oe_n(oe_n),
		.soft_reset_pulse(srst), .cfg(cfg));
	acsr_host host_u (.clk_sys(clk_sys), .serial_readout_pin(serial_readout_pin_w), .sen_n(sen_n),
		.sclk(sclk), .sdata(sdata));

	always @(posedge clk_sys)
		if (srst === 1'b1)
			srst_seen++;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] s);
		n_compared++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		host_u.xfer(a, d, q);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] e);
		exp_q.push_back(e);
		host_u.xfer(a, d, rd);
		rd_stb = 1'b1;
		#1 rd_stb = 1'b0;
	endtask
	task automatic read_all();
		for (int i = 0; i < acsr_pkg::NUM_REGS; i++)
			rd_reg(acsr_pkg::REG_ADDR[i], i == 0 ? 8'h01 : 8'($urandom()),
				shadow[i]);
		rd_reg(8'h02, 8'($urandom()), 8'h00);
	endtask
	task automatic close_out();
		if (error_cnt == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge rd_stb)
		chk("readback", exp_q.pop_front(), rd);

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [7:0] d;
		d = 8'($urandom(83));
		repeat (16) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		chk("cfg_clear", 8'h00, {7'h00, |cfg});
		chk("oe_n", 8'h01, {7'h00, oe_n});
		repeat (2) @(posedge clk_sys);
		for (int i = 1; i < acsr_pkg::NUM_REGS; i++)
		begin
			d = 8'($urandom()) & acsr_pkg::REG_MASK[i];
			shadow[i] = d;
			wr(acsr_pkg::REG_ADDR[i], d);
		end
		shadow[0] = 8'h00;
		chk("filter_b", {1'h0, shadow[4][6:0]}, {1'h0, cfg.filter_b});
		chk("aux", {2'h0, shadow[2][5:0]}, {2'h0, cfg.aux_ctrl});
		chk("swen", {6'h00, shadow[14][1:0]}, {6'h00, cfg.swing_prog_en});
		chk("hf", {4'h0, shadow[10][0], shadow[9][0], shadow[7][0],
			shadow[8][0]}, {4'h0, cfg.hf_mode_dcba});
		chk("misc", {3'h0, shadow[5][6], shadow[13][7], shadow[11][7:5]},
			{3'h0, cfg.shaping_en_b, cfg.noise_shaping_pin_override,
			cfg.value_a_d});
		chk("ofs", {3'h0, shadow[12][7], shadow[12][5:2]}, {3'h0,
			cfg.offset_loop_hold, cfg.offset_loop_time_constant});
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h01, {SW[i], 2'h0});
			chk("swing", {2'h0, SW[i]}, {2'h0, cfg.swing_code});
		end
		@(posedge clk_sys) #1 feat_en = 1'b1;
		for (int p = 0; p < 3; p++)
		begin
			wr(8'h25, {4'(12 - p), 1'b0, 3'(p)});
			chk("gain_b", 8'(12 - p), {4'h0, cfg.gain_b});
			chk("pattern_b", 8'(p), {5'h00, cfg.pattern_b});
		end
		@(posedge clk_sys) #1 feat_en = 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("pattern_off", 8'h00, {5'h00, cfg.pattern_b});
		for (int f = 0; f < 4; f++)
		begin
			wr(8'h29, 8'(f << 3));
			chk("fmt", {7'h00, f == 3}, {7'h00, cfg.offset_binary_ab});
		end
		shadow[1] = 8'h3C;
		shadow[3] = 8'hA2;
		shadow[6] = 8'h18;
		wr(8'h00, 8'h01);
		shadow[0] = 8'h01;
		chk("oe_n", 8'h00, {7'h00, oe_n});
		// second pass proves the reads' random data bytes were not stored
		read_all();
		read_all();
		d = 8'(srst_seen);
		wr(8'h00, 8'h03);
		chk("srst_pulses", 8'h01, 8'(srst_seen) - d);
		chk("cfg_clear", 8'h00, {7'h00, |cfg});
		chk("oe_n", 8'h01, {7'h00, oe_n});
		for (int i = 1; i < acsr_pkg::NUM_REGS; i++)
			shadow[i] = 8'h00;
		wr(8'h00, 8'h01);
		read_all();
		close_out();
	end

	initial
	begin
		repeat (40000) @(posedge clk_sys);
		error_cnt++;
		close_out();
	end
endmodule // acsr_bank_tb
`default_nettype wire

// ### bench/acsr_host.sv
// host model driving the serial configuration port
`timescale 1ns/100ps
`default_nettype none
module acsr_host (
	input wire logic clk_sys,
	input wire logic serial_readout_pin,
	output logic sen_n,
	output logic sclk,
	output logic sdata
);
	initial
	begin
		sen_n = 1'b1;
		sclk = 1'b0;
		sdata = 1'b0;
	end
	// address then data, msb first; readback taken at rises 9..16
	// low phase of 3 cycles leaves the readout bit two cycles to settle
	task automatic xfer(input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] f;
		f = {a, d};
		@(posedge clk_sys) #1 sen_n = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			sdata = f[i];
			repeat (3) @(posedge clk_sys);
			#1 sclk = 1'b1;
			if (i < 8)
				q[i] = serial_readout_pin;
			repeat (2) @(posedge clk_sys);
			#1 sclk = 1'b0;
		end
		repeat (2) @(posedge clk_sys);
		#1 sen_n = 1'b1;
		sdata = ~sdata;
		repeat (6) @(posedge clk_sys);
	endtask
endmodule // acsr_host
`default_nettype wire

// ### hw/acsr_bank.sv
// configuration register bank behind the serial control port
`timescale 1ns/100ps
`default_nettype none
module acsr_bank (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic sen_n,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic digital_features_en,
	output logic serial_readout_pin_o,
	output logic serial_readout_pin_oe_n,
	output logic soft_reset_pulse,
	output acsr_pkg::acsr_cfg_t cfg
);
	logic [7:0] q [acsr_pkg::NUM_REGS];
	acsr_pkg::acsr_wr_t wr_reg;
	acsr_pkg::acsr_state_t state_reg;
	logic sclk_prev_reg;
	logic [4:0] cnt_reg;
	logic [14:0] shift_in_reg;
	logic [7:0] shift_out_reg;
	logic serial_readout_pin_reg;
	logic oe_n_reg;
	logic soft_rst_reg;
	acsr_pkg::acsr_cfg_t cfg_reg;
	logic sclk_rise;
	logic sclk_fall;
	logic readout_en;
	logic clear_all;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic [7:0] wr_addr_next;
	logic [7:0] wr_data_next;

	////////////////////////////////////////////////////////////////////////
	// register cells

	// clear and write arrive together; clear wins so readout bit 0 written with it is dropped
	assign clear_all = wr_reg.en
		&& wr_reg.addr == acsr_pkg::REG_ADDR[acsr_pkg::IX_CTRL]
		&& wr_reg.data[acsr_pkg::CTRL_SWRST_BIT];

	generate
		for (genvar i = 0; i < acsr_pkg::NUM_REGS; i++)
		begin : g_cell
			acsr_cell #(
				.ADDR(acsr_pkg::REG_ADDR[i]),
				.MASK(acsr_pkg::REG_MASK[i])
			) u_cell (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.wr(wr_reg),
				.clear(clear_all),
				.q(q[i])
			);
		end
	endgenerate

	assign readout_en = q[acsr_pkg::IX_CTRL][acsr_pkg::CTRL_READOUT_BIT];

	always_comb
	begin
		rd_data = 8'h00;
		for (int i = 0; i < acsr_pkg::NUM_REGS; i++)
			if (rd_addr == acsr_pkg::REG_ADDR[i])
				rd_data = q[i];
	end

	////////////////////////////////////////////////////////////////////////
	// serial frame: 8 address bits then 8 data bits, msb first, on sclk rise

	assign sclk_rise = sclk && !sclk_prev_reg;
	assign sclk_fall = !sclk && sclk_prev_reg;
	assign rd_addr = {shift_in_reg[6:0], sdata};
	assign wr_addr_next = shift_in_reg[14:7];
	assign wr_data_next = {shift_in_reg[6:0], sdata};

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			sclk_prev_reg <= 1'b0;
		else
			sclk_prev_reg <= sclk;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= acsr_pkg::ST_IDLE;
			cnt_reg <= 5'h00;
			shift_in_reg <= 15'h0000;
		end
		else if (sen_n)
		begin
			state_reg <= acsr_pkg::ST_IDLE;
			cnt_reg <= 5'h00;
		end
		else if (sclk_rise && cnt_reg <= acsr_pkg::CNT_LAST)
		begin
			state_reg <= acsr_pkg::ST_FRAME;
			cnt_reg <= cnt_reg + 5'h01;
			shift_in_reg <= {shift_in_reg[13:0], sdata};
		end
	end

	// while readback is on, only address 0x00 accepts writes, so readout
	// can always be switched off again
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			wr_reg <= '0;
		else if (!sen_n && sclk_rise && cnt_reg == acsr_pkg::CNT_LAST
			&& (!readout_en
			|| wr_addr_next == acsr_pkg::REG_ADDR[acsr_pkg::IX_CTRL]))
		begin
			wr_reg.en <= 1'b1;
			wr_reg.addr <= wr_addr_next;
			wr_reg.data <= wr_data_next;
		end
		else
			wr_reg.en <= 1'b0;
	end

	// data bits leave on sclk falling edges for the host to sample on rise
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_out_reg <= 8'h00;
			serial_readout_pin_reg <= 1'b0;
		end
		else if (!sen_n && sclk_rise && cnt_reg == acsr_pkg::CNT_ADDR_LAST)
			shift_out_reg <= readout_en ? rd_data : 8'h00;
		else if (!sen_n && sclk_fall && cnt_reg >= acsr_pkg::CNT_DATA_FIRST
			&& cnt_reg <= acsr_pkg::CNT_LAST)
		begin
			serial_readout_pin_reg <= shift_out_reg[7];
			shift_out_reg <= {shift_out_reg[6:0], 1'b0};
		end
		else if (sen_n)
			serial_readout_pin_reg <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			oe_n_reg <= 1'b1;
		else
			oe_n_reg <= !readout_en;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			soft_rst_reg <= 1'b0;
		else
			soft_rst_reg <= clear_all;
	end

	////////////////////////////////////////////////////////////////////////
	// decoded configuration, one flop stage after the cells

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cfg_reg <= '0;
		else
		begin
			cfg_reg.swing_code <= q[acsr_pkg::IX_SWING][7:acsr_pkg::SWING_LSB];
			cfg_reg.swing_prog_en <= q[acsr_pkg::IX_SWEN][1:0];
			cfg_reg.aux_ctrl <= q[acsr_pkg::IX_AUX][5:0];
			cfg_reg.gain_b <= q[acsr_pkg::IX_GAIN_B][7:acsr_pkg::GAIN_LSB];
			// pattern is forced to normal data unless digital features are on
			cfg_reg.pattern_b <= digital_features_en
				? q[acsr_pkg::IX_GAIN_B][2:0] : acsr_pkg::PAT_NORMAL;
			cfg_reg.filter_b <= q[acsr_pkg::IX_FILT_B][6:0];
			cfg_reg.shaping_en_b <= q[acsr_pkg::IX_SHAPE_B][acsr_pkg::SHAPE_EN_BIT];
			cfg_reg.offset_binary_ab <= q[acsr_pkg::IX_FMT_AB][acsr_pkg::FMT_LSB+:2]
				== acsr_pkg::FMT_OFFSET_BIN;
			cfg_reg.hf_mode_dcba <= {q[acsr_pkg::IX_HF_D][0], q[acsr_pkg::IX_HF_C][0],
				q[acsr_pkg::IX_HF_B][0], q[acsr_pkg::IX_HF_A][0]};
			cfg_reg.value_a_d <= q[acsr_pkg::IX_PED_D][7:acsr_pkg::PED_LSB];
			cfg_reg.offset_loop_hold <= q[acsr_pkg::IX_OFS][acsr_pkg::OFS_HOLD_BIT];
			cfg_reg.offset_loop_time_constant <=
				q[acsr_pkg::IX_OFS][acsr_pkg::OFS_TC_LSB+:4];
			cfg_reg.noise_shaping_pin_override <=
				q[acsr_pkg::IX_OVR][acsr_pkg::OVR_BIT];
		end
	end

	assign serial_readout_pin_o = serial_readout_pin_reg;
	assign serial_readout_pin_oe_n = oe_n_reg;
	assign soft_reset_pulse = soft_rst_reg;
	assign cfg = cfg_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	swrst_clears_all_a: assert property (clear_all |=> (q[acsr_pkg::IX_SWING] == 8'h00 && q[acsr_pkg::IX_OFS] == 8'h00 && q[acsr_pkg::IX_CTRL] == 8'h00) ##1 (cfg == '0 || wr_reg.en))
		else $error("software reset did not clear the bank");
	swrst_selfclear_a: assert property (q[acsr_pkg::IX_CTRL][acsr_pkg::CTRL_SWRST_BIT] == 1'b0)
		else $error("software reset bit did not self-clear");
	swrst_pulse_a: assert property (clear_all |=> soft_reset_pulse ##1 !soft_reset_pulse || clear_all)
		else $error("soft reset pulse wrong");
	readout_hiz_a: assert property (!readout_en [*2] |-> serial_readout_pin_oe_n)
		else $error("readout pin driven while readback disabled");
	readout_drive_a: assert property ($rose(readout_en) |=> !serial_readout_pin_oe_n)
		else $error("readout pin not driven while readback enabled");
	write_whole_a: assert property (wr_reg.en && !clear_all && wr_reg.addr == acsr_pkg::REG_ADDR[acsr_pkg::IX_GAIN_B] |=> q[acsr_pkg::IX_GAIN_B] == ($past(wr_reg.data) & acsr_pkg::REG_MASK[acsr_pkg::IX_GAIN_B]))
		else $error("write did not update all fields");
	swing_field_a: assert property (##1 cfg.swing_code == $past(q[acsr_pkg::IX_SWING][7:2]))
		else $error("swing code does not follow its register");
	gain_field_a: assert property (##1 cfg.gain_b == $past(q[acsr_pkg::IX_GAIN_B][7:4]))
		else $error("gain does not follow its register");
	format_sel_a: assert property (q[acsr_pkg::IX_FMT_AB][4:3] != 2'h3 |=> !cfg.offset_binary_ab)
		else $error("offset binary chosen for a two's complement code");
	pattern_gate_a: assert property (!digital_features_en |=> cfg.pattern_b == 3'h0)
		else $error("test pattern active without digital features");
	filter_field_a: assert property (##1 cfg.filter_b == $past(q[acsr_pkg::IX_FILT_B][6:0]))
		else $error("filter select does not follow its register");
	reset_zero_a: assert property ($rose(rst_n) |-> q[acsr_pkg::IX_PED_D] == 8'h00 && cfg == '0)
		else $error("register not zero after reset");

	cov_write_c: cover property (wr_reg.en && wr_reg.addr == acsr_pkg::REG_ADDR[acsr_pkg::IX_SWING]);
	cov_swrst_c: cover property (clear_all);
	cov_read_c: cover property (readout_en && !sen_n && sclk_fall && cnt_reg == acsr_pkg::CNT_LAST);
endmodule // acsr_bank
`default_nettype wire

// ### hw/acsr_cell.sv
// one configuration register with its own address and writable mask
`timescale 1ns/100ps
`default_nettype none
module acsr_cell #(
	parameter logic [7:0] ADDR = 8'h00,
	parameter logic [7:0] MASK = 8'hFF
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire acsr_pkg::acsr_wr_t wr,
	input wire logic clear,
	output logic [7:0] q
);
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			q <= acsr_pkg::RST_VAL;
		else if (clear)
			q <= acsr_pkg::RST_VAL;
		else if (wr.en && wr.addr == ADDR)
			q <= wr.data & MASK;
	end
endmodule // acsr_cell
`default_nettype wire

// ### hw/acsr_pkg.sv
// package: register map, field layout and types of the configuration bank
// Summary of operation
// - every configuration register is zero after device reset.
// - one write updates every field of the addressed register together.
// - writing 1 to bit 1 at address 0x00 clears all registers; bit self-clears.
// - readout bit 0 at 0x00 low: no readback, readout pin high impedance.
// - readout bit high: readout pin driven, shifts register contents on reads.
// - bits 7..2 of 0x01 hold the six-bit output swing code.
// - four-bit gain field, half-decibel steps, 0000 to 1100.
// - format field 11 gives offset binary, other codes two's complement.
// - test pattern acts only while digital-features enable is set.
// - seven-bit filter field picks one of 55 noise-shaping filters.
`default_nettype none
package acsr_pkg;
	localparam int NUM_REGS = 15;
	localparam int FRAME_BITS = 16;
	localparam logic [7:0] RST_VAL = 8'h00;
	// register indices into the table below
	localparam int IX_CTRL = 0;
	localparam int IX_SWING = 1;
	localparam int IX_AUX = 2;
	localparam int IX_GAIN_B = 3;
	localparam int IX_FILT_B = 4;
	localparam int IX_SHAPE_B = 5;
	localparam int IX_FMT_AB = 6;
	localparam int IX_HF_B = 7;
	localparam int IX_HF_A = 8;
	localparam int IX_HF_C = 9;
	localparam int IX_HF_D = 10;
	localparam int IX_PED_D = 11;
	localparam int IX_OFS = 12;
	localparam int IX_OVR = 13;
	localparam int IX_SWEN = 14;
	localparam logic [7:0] REG_ADDR [NUM_REGS] = '{8'h00, 8'h01, 8'h03,
		8'h25, 8'h26, 8'h28, 8'h29, 8'h4A, 8'h58, 8'h66, 8'h74, 8'hC5,
		8'hCF, 8'hEA, 8'hF1};
	// writable bits; bit 1 of 0x00 is never stored so it reads zero
	localparam logic [7:0] REG_MASK [NUM_REGS] = '{8'h01, 8'hFC, 8'h3F,
		8'hF7, 8'h7F, 8'h40, 8'h18, 8'h01, 8'h01, 8'h01, 8'h01, 8'hE0,
		8'hBC, 8'h80, 8'h03};
	localparam int CTRL_READOUT_BIT = 0;
	localparam int CTRL_SWRST_BIT = 1;
	localparam int SWING_LSB = 2;
	localparam int GAIN_LSB = 4;
	localparam int FMT_LSB = 3;
	localparam logic [1:0] FMT_OFFSET_BIN = 2'h3;
	localparam int SHAPE_EN_BIT = 6;
	localparam int PED_LSB = 5;
	localparam int OFS_HOLD_BIT = 7;
	localparam int OFS_TC_LSB = 2;
	localparam int OVR_BIT = 7;
	localparam logic [2:0] PAT_NORMAL = 3'h0;
	localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
	localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
	localparam logic [4:0] CNT_LAST = 5'h0F;

	typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_FRAME = 1'b1} acsr_state_t;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} acsr_wr_t;

	typedef struct packed {
		logic [5:0] swing_code;
		logic [1:0] swing_prog_en;
		logic [5:0] aux_ctrl;
		logic [3:0] gain_b;
		logic [2:0] pattern_b;
		logic [6:0] filter_b;
		logic shaping_en_b;
		logic offset_binary_ab;
		logic [3:0] hf_mode_dcba;
		logic [2:0] value_a_d;
		logic offset_loop_hold;
		logic [3:0] offset_loop_time_constant;
		logic noise_shaping_pin_override;
	} acsr_cfg_t;
endpackage
`default_nettype wire
